/* File: src/data_move_pkg.sv */
// What this block does
// [RULE1] Register copy moves register to accumulator if bit clear, else back to register
// [RULE2] Register copy sets the zero flag from the moved value
// [RULE3] Accumulator store writes accumulator to 7-bit addressed register, flags unchanged
// [RULE4] Literal load puts 8-bit immediate into accumulator, flags unchanged
// [RULE5] Return from interrupt pops stack top into counter and sets global irq enable
// [RULE6] Return with literal loads accumulator and pops stack top into counter
// [RULE7] Return with literal takes two cycles; the following fetched word is discarded
// [RULE8] Idle op takes one cycle, changes nothing, advances counter by one
package data_move_pkg;
    localparam int unsigned INSN_W   = 14;
    localparam int unsigned PC_W     = 13;
    localparam int unsigned ADDR_W   = 7;
    localparam int unsigned DATA_W   = 8;
    localparam int unsigned DEST_BIT = 7;

    localparam logic [PC_W-1:0]   PC_RESET  = 13'h0000;
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;

    // Opcode patterns
    localparam logic [13:0] OP_IDLE     = 14'h0000;
    localparam logic [13:0] OP_RETIRQ   = 14'h0009;
    localparam logic [5:0]  OP_COPY     = 6'h08;   // bits 13:8
    localparam logic [6:0]  OP_STORE    = 7'h01;   // bits 13:7
    localparam logic [3:0]  OP_LOADLIT  = 4'hC;    // bits 13:10
    localparam logic [3:0]  OP_RETLIT   = 4'hD;    // bits 13:10

    typedef enum logic [2:0] {
        INS_IDLE    = 3'b000,
        INS_COPY    = 3'b001,
        INS_STORE   = 3'b010,
        INS_LOADLIT = 3'b011,
        INS_RETIRQ  = 3'b100,
        INS_RETLIT  = 3'b101,
        INS_OTHER   = 3'b110
    } insn_t;

    typedef enum logic [0:0] {
        ST_RUN   = 1'b0,
        ST_FLUSH = 1'b1
    } seq_t;
endpackage

/* File: src/data_move_return_ops.sv */
`timescale 1ns/1ps
module data_move_return_ops (
    input  wire logic                                clk,
    input  wire logic                                arst_n,
    input  wire logic                                insnValid,
    input  wire logic [data_move_pkg::INSN_W-1:0]    insn,
    input  wire logic [data_move_pkg::DATA_W-1:0]    regRdData,
    input  wire logic [data_move_pkg::PC_W-1:0]      stackTopEntry,
    output logic      [data_move_pkg::ADDR_W-1:0]    regAddr_reg,
    output logic      [data_move_pkg::DATA_W-1:0]    regWrData_reg,
    output logic                                     regWrEn_reg,
    output logic      [data_move_pkg::DATA_W-1:0]    acc_reg,
    output logic                                     zeroFlag_reg,
    output logic                                     globalIrqOn_reg,
    output logic      [data_move_pkg::PC_W-1:0]      pc_reg,
    output logic                                     stackPop_reg,
    output logic                                     fetchDiscard_reg,
    output logic                                     done_reg
);
    import data_move_pkg::*;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    insn_t kind;
    seq_t  seq_reg;
    logic  exec;

    insn_classify uDecode (
        .insn (insn),
        .kind (kind)
    );

    // The word fetched behind a return is dropped while flushing
    assign exec = insnValid && (seq_reg == ST_RUN);

    logic [DATA_W-1:0] literal;
    logic [ADDR_W-1:0] fAddr;
    logic              destSelf;
    assign literal  = insn[DATA_W-1:0];
    assign fAddr    = insn[ADDR_W-1:0];
    assign destSelf = insn[DEST_BIT];

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Both returns pop the stack and drop the word fetched behind them
    function automatic logic isReturn(input insn_t k);
        return (k == INS_RETLIT) || (k == INS_RETIRQ);
    endfunction

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            seq_reg <= ST_RUN;
        end else begin
            unique case (seq_reg)
                ST_RUN: begin
                    // A taken return blocks issue for exactly one cycle
                    if (exec && isReturn(kind)) begin
                        seq_reg <= ST_FLUSH; // RULE7
                    end
                end
                ST_FLUSH: begin
                    seq_reg <= ST_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fetchDiscard_reg <= 1'b0;
            stackPop_reg     <= 1'b0;
            done_reg         <= 1'b0;
        end else begin
            fetchDiscard_reg <= exec && isReturn(kind); // RULE7
            stackPop_reg     <= exec && isReturn(kind); // RULE5 RULE6
            done_reg         <= exec;
        end
    end

    // ------------------------------------------------------------
    // Program counter
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pc_reg <= PC_RESET;
        end else if (exec) begin
            if (isReturn(kind)) begin
                pc_reg <= stackTopEntry; // RULE5 RULE6
            end else begin
                // Unknown opcodes also land here and just advance
                pc_reg <= pc_reg + PC_W'(1); // RULE8
            end
        end
    end

    // ------------------------------------------------------------
    // Accumulator and flags
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            acc_reg <= ACC_RESET;
        end else if (exec) begin
            if (kind == INS_COPY && !destSelf) begin
                acc_reg <= regRdData; // RULE1
            end else if (kind == INS_LOADLIT || kind == INS_RETLIT) begin
                acc_reg <= literal; // RULE4 RULE6
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            zeroFlag_reg <= 1'b0;
        end else if (exec && kind == INS_COPY) begin
            // Only the copy moves the flag; every other instruction leaves it
            zeroFlag_reg <= (regRdData == '0); // RULE2
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            globalIrqOn_reg <= 1'b0;
        end else if (exec && kind == INS_RETIRQ) begin
            globalIrqOn_reg <= 1'b1; // RULE5
        end
    end

    // ------------------------------------------------------------
    // Register file write port
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            regWrEn_reg   <= 1'b0;
            regWrData_reg <= ACC_RESET;
            regAddr_reg   <= '0;
        end else begin
            // Address and data load every cycle; the enable alone qualifies them
            regWrEn_reg <= exec && ((kind == INS_STORE) || (kind == INS_COPY && destSelf));
            regAddr_reg <= fAddr;
            if (kind == INS_STORE) begin
                regWrData_reg <= acc_reg; // RULE3
            end else begin
                regWrData_reg <= regRdData; // RULE1
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_retlit_taken;
        exec && kind == INS_RETLIT;
    endsequence

    sequence s_retirq_taken;
        exec && kind == INS_RETIRQ;
    endsequence

    // One dead cycle with the fetched word dropped, then normal issue again
    sequence s_flush_then_run;
        fetchDiscard_reg && !exec && seq_reg == ST_FLUSH
            ##1 !fetchDiscard_reg && seq_reg == ST_RUN;
    endsequence

    a_copy_to_acc: assert property (@(posedge clk) disable iff (!arst_n) // RULE1
        exec && kind == INS_COPY && !destSelf |=> acc_reg == $past(regRdData))
        else $error("copy to accumulator lost");
    a_copy_zero: assert property (@(posedge clk) disable iff (!arst_n) // RULE2
        exec && kind == INS_COPY |=> zeroFlag_reg == ($past(regRdData) == 8'h00))
        else $error("zero flag wrong after copy");
    a_store_data: assert property (@(posedge clk) disable iff (!arst_n) // RULE3
        exec && kind == INS_STORE |=> regWrEn_reg && regWrData_reg == $past(acc_reg)
            && $stable(zeroFlag_reg))
        else $error("store wrong");
    a_loadlit_acc: assert property (@(posedge clk) disable iff (!arst_n) // RULE4
        exec && kind == INS_LOADLIT |=> acc_reg == $past(insn[7:0]) && $stable(zeroFlag_reg))
        else $error("literal load wrong");
    a_retirq_pop: assert property (@(posedge clk) disable iff (!arst_n) // RULE5
        exec && kind == INS_RETIRQ |=> globalIrqOn_reg && pc_reg == $past(stackTopEntry))
        else $error("return from irq wrong");
    a_retlit_pop: assert property (@(posedge clk) disable iff (!arst_n) // RULE6
        s_retlit_taken |=> pc_reg == $past(stackTopEntry) && acc_reg == $past(insn[7:0]))
        else $error("return with literal wrong");
    a_retlit_flush: assert property (@(posedge clk) disable iff (!arst_n) // RULE7
        s_retlit_taken |=> s_flush_then_run)
        else $error("return with literal not two cycles");
    a_idle_advance: assert property (@(posedge clk) disable iff (!arst_n) // RULE8
        exec && kind == INS_IDLE |=> pc_reg == $past(pc_reg) + 13'h0001 && $stable(acc_reg)
            && !regWrEn_reg && $stable(zeroFlag_reg) && !stackPop_reg)
        else $error("idle op changed state");

    // ------------------------------------------------------------
    // Return, flush, copy-back and store-target checks
    // ------------------------------------------------------------
    a_retlit_flags: assert property (@(posedge clk) disable iff (!arst_n) // RULE6
        s_retlit_taken |=> stackPop_reg && !regWrEn_reg && $stable(zeroFlag_reg)
            && $stable(globalIrqOn_reg))
        else $error("return with literal touched flags");
    a_retirq_flags: assert property (@(posedge clk) disable iff (!arst_n) // RULE5
        s_retirq_taken |=> stackPop_reg && !regWrEn_reg && $stable(zeroFlag_reg)
            && $stable(acc_reg))
        else $error("return from irq touched flags");
    a_retirq_flush: assert property (@(posedge clk) disable iff (!arst_n) // RULE5
        s_retirq_taken |=> s_flush_then_run)
        else $error("return from irq word not dropped");
    a_flush_quiet: assert property (@(posedge clk) disable iff (!arst_n) // RULE7
        seq_reg == ST_FLUSH |=> !done_reg && !regWrEn_reg && !stackPop_reg
            && $stable(pc_reg) && $stable(acc_reg) && $stable(zeroFlag_reg))
        else $error("dropped word had an effect");
    a_copy_to_reg: assert property (@(posedge clk) disable iff (!arst_n) // RULE1
        exec && kind == INS_COPY && destSelf |=> regWrEn_reg && $stable(acc_reg)
            && regWrData_reg == $past(regRdData) && regAddr_reg == $past(fAddr))
        else $error("copy back to register lost");
    a_store_target: assert property (@(posedge clk) disable iff (!arst_n) // RULE3
        exec && kind == INS_STORE |=> regAddr_reg == $past(fAddr) && $stable(acc_reg)
            && $stable(globalIrqOn_reg))
        else $error("store went to wrong register");
endmodule

/* File: src/insn_classify.sv */
`timescale 1ns/1ps
module insn_classify (
    input  wire logic [data_move_pkg::INSN_W-1:0] insn,
    output data_move_pkg::insn_t                   kind
);
    import data_move_pkg::*;

    always_comb begin
        if (insn == OP_IDLE) begin
            kind = INS_IDLE;
        end else if (insn == OP_RETIRQ) begin
            kind = INS_RETIRQ;
        end else if (insn[13:8] == OP_COPY) begin
            kind = INS_COPY;
        end else if (insn[13:7] == OP_STORE) begin
            kind = INS_STORE;
        end else if (insn[13:10] == OP_LOADLIT) begin
            kind = INS_LOADLIT;
        end else if (insn[13:10] == OP_RETLIT) begin
            kind = INS_RETLIT;
        end else begin
            kind = INS_OTHER;
        end
    end
endmodule

/* File: test/test_data_move_return_ops.sv */
`timescale 1ns/1ps
module test_data_move_return_ops;
    import data_move_pkg::*;
    typedef struct {
        logic [13:0] op;
        logic [7:0]  rd;
        logic [7:0]  acc;
        logic        z;
        logic        we;
        logic [7:0]  wd;
        logic [6:0]  ad;
    } row_t;
    logic        clk, arstN, insnValid, regWrEn, zeroFlag, irqOn, stackPop, fetchDiscard, done;
    logic [13:0] insn;
    logic [7:0]  regRdData, regWrData, acc;
    logic [12:0] stackTopEntry, pc, pcExp;
    logic [6:0]  regAddr;
    int          miscompares, nChecks;
    row_t        rows[12] = '{
        '{14'h30A5, 8'h00, 8'hA5, 1'b0, 1'b0, 8'h00, 7'h00},
        '{14'h0805, 8'h00, 8'h00, 1'b1, 1'b0, 8'h00, 7'h00},
        '{14'h08FF, 8'h3C, 8'h00, 1'b0, 1'b1, 8'h3C, 7'h7F},
        '{14'h305A, 8'h00, 8'h5A, 1'b0, 1'b0, 8'h00, 7'h00},
        '{14'h0080, 8'h00, 8'h5A, 1'b0, 1'b1, 8'h5A, 7'h00},
        '{14'h00FF, 8'h00, 8'h5A, 1'b0, 1'b1, 8'h5A, 7'h7F},
        '{14'h0880, 8'h00, 8'h5A, 1'b1, 1'b1, 8'h00, 7'h00},
        '{14'h3000, 8'h00, 8'h00, 1'b1, 1'b0, 8'h00, 7'h00},
        '{14'h33FF, 8'h00, 8'hFF, 1'b1, 1'b0, 8'h00, 7'h00},
        '{14'h0000, 8'h00, 8'hFF, 1'b1, 1'b0, 8'h00, 7'h00},
        '{14'h08C3, 8'h80, 8'hFF, 1'b0, 1'b1, 8'h80, 7'h43},
        '{14'h3800, 8'h00, 8'hFF, 1'b0, 1'b0, 8'h00, 7'h00}};

    data_move_return_ops DUT (
        .clk(clk), .arst_n(arstN), .insnValid(insnValid), .insn(insn),
        .regRdData(regRdData), .stackTopEntry(stackTopEntry), .regAddr_reg(regAddr),
        .regWrData_reg(regWrData), .regWrEn_reg(regWrEn), .acc_reg(acc),
        .zeroFlag_reg(zeroFlag), .globalIrqOn_reg(irqOn), .pc_reg(pc),
        .stackPop_reg(stackPop), .fetchDiscard_reg(fetchDiscard), .done_reg(done));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] s);
        nChecks++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic conclude();
        $display("checks %0d miscompares %0d", nChecks, miscompares);
        if (miscompares == 0 && nChecks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic step(input logic [13:0] op, input logic [7:0] rd);
        @(posedge clk);
        insn <= op;
        regRdData <= rd;
        insnValid <= 1'b1;
        @(posedge clk);
        insnValid <= 1'b0;
        #1;
        pcExp = pcExp + 13'h0001;
    endtask

    // Return, with the next word held valid so that it must be dropped
    task automatic ret(input logic [13:0] op);
        @(posedge clk);
        insn <= op;
        insnValid <= 1'b1;
        @(posedge clk);
        insn <= OP_IDLE;
        #1;
        chk("pop", {2'b11, stackTopEntry}, {stackPop, fetchDiscard, pc});
        chk("pc", stackTopEntry, pc);
        @(posedge clk);
        insnValid <= 1'b0;
        #1;
        chk("dropped", {1'b0, stackTopEntry}, {done, pc});
        pcExp = stackTopEntry;
    endtask

    // ------------------------------------------------------------
    // Clock, watchdog, sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        #(8 * 400);
        miscompares++;
        conclude();
    end

    initial begin
        arstN = 1'b0;
        insnValid = 1'b0;
        insn = '0;
        regRdData = '0;
        stackTopEntry = 13'h0ABC;
        pcExp = '0;
        repeat (4) @(posedge clk);
        arstN <= 1'b1;
        #1;
        chk("reset", 0, {regAddr, regWrData, regWrEn, acc, zeroFlag, irqOn, pc, stackPop,
                         fetchDiscard, done});
        foreach (rows[i]) begin
            step(rows[i].op, rows[i].rd);
            chk("acc", rows[i].acc, acc);
            chk("zero", rows[i].z, zeroFlag);
            chk("wren", rows[i].we, regWrEn);
            if (rows[i].we) chk("wr", {rows[i].wd, rows[i].ad}, {regWrData, regAddr});
            chk("done pc", {1'b1, pcExp}, {done, pc});
        end
        stackTopEntry = 13'h1D5E;
        ret(14'h37C3);
        chk("acc", {9'h0C3, 1'b0}, {irqOn, acc, zeroFlag});
        step(OP_IDLE, 8'h00);
        chk("pc", {1'b0, pcExp}, {stackPop, pc});
        stackTopEntry = 13'h0ABC;
        ret(OP_RETIRQ);
        chk("irq", {9'h1C3, 1'b0}, {irqOn, acc, zeroFlag});
        @(posedge clk);
        arstN <= 1'b0;
        #1;
        chk("midreset", 0, {regWrEn, acc, zeroFlag, irqOn, pc, stackPop, fetchDiscard, done});
        @(posedge clk);
        arstN <= 1'b1;
        pcExp = '0;
        step(OP_IDLE, 8'h00);
        chk("restart", {1'b1, pcExp}, {done, pc});
        conclude();
    end
endmodule
